// ---- pkg/ext_bus_defs.svh ----
// constants of the external bus access timing block
// included by the design files by bare name; definitions only
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// bus and field widths
`define ADDR_W 20
`define LEAD_W 2
`define ACTIVE_W 3
`define TRAIL_W 2
`define CNT_W 5
`define ACC_W 8

// reset values
`define ADDR_RST 20'h0_0000
`define CNT_RST 5'h00
`define ACC_RST 8'h00
`define PHASE_RST 2'h0

// timing counts: CNT_ONE in access-timing clock cycles, PHASE_ONE in system clock cycles
`define CNT_ONE 5'h01
`define PHASE_ONE 2'h1

`endif

// ---- pkg/ext_bus_pkg.sv ----
// types of the external bus access timing block
// used with explicit package scoping, never imported
package ext_bus_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_arm = 3'b001,
    st_align = 3'b010,
    st_lead = 3'b011,
    st_active = 3'b100,
    st_trail = 3'b101
  } access_state_t;

endpackage

// ---- rtl/access_clock_divider.sv ----
// divider making the access-timing tick and the bus output clock
// assumes clk is the system clock and rst_n is already synchronised
`timescale 1ns/10ps
`include "ext_bus_defs.svh"

module access_clock_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timing_half,
  input wire logic bus_half,
  output logic timing_tick,
  output logic bus_rise,
  output logic bus_clock_out
);

  logic [1:0] phase;
  wire [1:0] phase_last = {timing_half & bus_half, timing_half | bus_half};
  wire [1:0] next_phase = (phase >= phase_last) ? `PHASE_RST :
                          phase + `PHASE_ONE;
  wire [1:0] half_point = (timing_half & bus_half) ? 2'h2 : 2'h1;
  wire next_bus_high = (phase_last == `PHASE_RST) | (phase < half_point);

  // timing clock and bus clock are both counted off the system clock
  assign timing_tick = ~timing_half | ~phase[0];
  assign bus_rise = (phase == `PHASE_RST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `PHASE_RST;
      bus_clock_out <= 1'b0;
    end else begin
      phase <= next_phase;
      bus_clock_out <= next_bus_high;
    end
  end

endmodule

// ---- rtl/external_bus_access.sv ----
// access sequencer of the external parallel memory bus
// assumes req_* and configuration ports come from clk logic;
// ext_wait_ready and reset_n come from outside and are synchronised
`timescale 1ns/10ps
`include "ext_bus_defs.svh"

module external_bus_access (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic timing_half,
  input wire logic bus_half,
  input wire logic timing_double,
  input wire logic honor_wait_input,
  input wire logic wait_sample_async,
  input wire logic wide_bus,
  input wire logic [`LEAD_W-1:0] read_lead_count,
  input wire logic [`ACTIVE_W-1:0] read_active_count,
  input wire logic [`TRAIL_W-1:0] read_trail_count,
  input wire logic [`LEAD_W-1:0] write_lead_count,
  input wire logic [`ACTIVE_W-1:0] write_active_count,
  input wire logic [`TRAIL_W-1:0] write_trail_count,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`ADDR_W-1:0] req_address,
  input wire logic ext_wait_ready,
  output logic req_ready,
  output logic access_done,
  output logic bus_clock_out,
  output logic zone_select_n,
  output logic read_strobe_n,
  output logic write_strobe0_n,
  output logic write_strobe1_n,
  output logic read_not_write,
  output logic [`ADDR_W-1:0] ext_address
);

  logic rst_meta;
  logic rst_n;
  logic wait_meta;
  logic wait_sync;
  logic wait_late;
  logic timing_tick;
  logic bus_rise;
  ext_bus_pkg::access_state_t state;
  ext_bus_pkg::access_state_t next_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic [`ACC_W-1:0] acc;
  logic is_write;
  logic wide;
  logic [`ADDR_W-1:0] addr_hold;
  logic [`LEAD_W-1:0] lead_raw;
  logic [`ACTIVE_W-1:0] active_raw;
  logic [`TRAIL_W-1:0] trail_raw;
  logic dbl;
  logic use_wait;
  logic async_wait;
  logic next_strobe;
  logic next_select;
  logic next_done;
  logic start;

  // reset release and wait input synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_meta <= 1'b1;
      wait_sync <= 1'b1;
      wait_late <= 1'b1;
    end else begin
      wait_meta <= ext_wait_ready;
      wait_sync <= wait_meta;
      wait_late <= wait_sync;
    end
  end

  access_clock_divider divider (
    .clk(clk),
    .rst_n(rst_n),
    .timing_half(timing_half),
    .bus_half(bus_half),
    .timing_tick(timing_tick),
    .bus_rise(bus_rise),
    .bus_clock_out(bus_clock_out)
  );

  // phase lengths in timing cycles; settings are taken as given
  wire [`CNT_W-1:0] lead_len = dbl ? {2'b00, lead_raw, 1'b0} :
                               {3'b000, lead_raw};
  wire [`CNT_W-1:0] act_base = dbl ? {1'b0, active_raw, 1'b0} :
                               {2'b00, active_raw};
  wire [`CNT_W-1:0] act_len = act_base + `CNT_ONE;
  wire [`CNT_W-1:0] trail_len = dbl ? {2'b00, trail_raw, 1'b0} :
                                {3'b000, trail_raw};
  wire ready_seen = async_wait ? wait_late : wait_sync;
  wire wait_hold = use_wait & ~ready_seen;
  wire take = req_valid & req_ready;
  wire last = (cnt == `CNT_ONE);

  // next state and phase counter, advanced on timing ticks except the idle-to-arm step on a taken request
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_strobe = 1'b0;
    next_select = ~zone_select_n;
    next_done = 1'b0;
    start = 1'b0;
    case (state)
      ext_bus_pkg::st_idle: begin
        if (take) begin
          next_state = ext_bus_pkg::st_arm;
        end
      end
      ext_bus_pkg::st_arm: begin
        if (timing_tick) begin
          if (bus_rise) begin
            start = 1'b1;
          end else begin
            next_state = ext_bus_pkg::st_align;
          end
        end
      end
      ext_bus_pkg::st_align: begin
        if (timing_tick) begin
          start = 1'b1;
        end
      end
      ext_bus_pkg::st_lead: begin
        if (timing_tick & last) begin
          next_state = ext_bus_pkg::st_active;
          next_cnt = act_len;
          next_strobe = 1'b1;
        end else if (timing_tick) begin
          next_cnt = cnt - `CNT_ONE;
        end
      end
      ext_bus_pkg::st_active: begin
        next_strobe = 1'b1;
        if (timing_tick & last & ~wait_hold) begin
          next_strobe = 1'b0;
          next_cnt = trail_len;
          if (trail_len == `CNT_RST) begin
            next_state = ext_bus_pkg::st_idle;
            next_select = 1'b0;
            next_done = 1'b1;
          end else begin
            next_state = ext_bus_pkg::st_trail;
          end
        end else if (timing_tick & ~last) begin
          next_cnt = cnt - `CNT_ONE;
        end
      end
      ext_bus_pkg::st_trail: begin
        if (timing_tick & last) begin
          next_state = ext_bus_pkg::st_idle;
          next_select = 1'b0;
          next_done = 1'b1;
        end else if (timing_tick) begin
          next_cnt = cnt - `CNT_ONE;
        end
      end
      default: begin
        next_state = ext_bus_pkg::st_idle;
      end
    endcase
    if (start) begin
      next_select = 1'b1;
      if (lead_len == `CNT_RST) begin
        next_state = ext_bus_pkg::st_active;
        next_cnt = act_len;
        next_strobe = 1'b1;
      end else begin
        next_state = ext_bus_pkg::st_lead;
        next_cnt = lead_len;
      end
    end
  end

  // request capture; settings other than timing_half and bus_half are frozen for the whole access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      wide <= 1'b0;
      addr_hold <= `ADDR_RST;
      lead_raw <= '0;
      active_raw <= '0;
      trail_raw <= '0;
      dbl <= 1'b0;
      use_wait <= 1'b0;
      async_wait <= 1'b0;
    end else if (take) begin
      is_write <= req_write;
      wide <= wide_bus;
      addr_hold <= req_address;
      lead_raw <= req_write ? write_lead_count : read_lead_count;
      active_raw <= req_write ? write_active_count : read_active_count;
      trail_raw <= req_write ? write_trail_count : read_trail_count;
      dbl <= timing_double;
      use_wait <= honor_wait_input;
      async_wait <= wait_sample_async;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ext_bus_pkg::st_idle;
      cnt <= `CNT_RST;
      acc <= `ACC_RST;
      req_ready <= 1'b0;
      access_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc <= start ? `ACC_RST : acc + {7'h00, timing_tick};
      req_ready <= (next_state == ext_bus_pkg::st_idle);
      access_done <= next_done;
    end
  end

  // pin drivers, all changed in the same edge as a timing tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_select_n <= 1'b1;
      read_not_write <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe0_n <= 1'b1;
      write_strobe1_n <= 1'b1;
      ext_address <= `ADDR_RST;
    end else begin
      zone_select_n <= ~next_select;
      read_not_write <= next_select ? ~is_write : 1'b1;
      read_strobe_n <= ~(next_strobe & ~is_write);
      write_strobe0_n <= ~(next_strobe & is_write);
      write_strobe1_n <= ~(next_strobe & is_write & wide);
      ext_address <= start ? addr_hold : ext_address;
    end
  end

  strobe_on_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(read_strobe_n) || $changed(write_strobe0_n) ||
    $changed(zone_select_n) |-> $past(timing_tick))
    else $error("strobe changed off a timing tick");

  start_on_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(zone_select_n) |-> bus_clock_out && $past(bus_rise))
    else $error("access did not start on a bus clock rise");

  write_rnw_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_strobe0_n |-> !read_not_write && !zone_select_n)
    else $error("write strobe without select and rnw low");

  strobe_lead_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(read_strobe_n) || $fell(write_strobe0_n)
    |-> acc == lead_len)
    else $error("strobe fell after the wrong lead length");

  half_parity_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus_half && ($changed(read_strobe_n) || $changed(write_strobe0_n) ||
    $changed(zone_select_n)) |-> bus_clock_out == ~acc[0])
    else $error("strobe edge does not match count parity");

  equal_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_half && $changed(zone_select_n) |-> $past(bus_rise))
    else $error("select changed off a bus clock rise");

  no_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == ext_bus_pkg::st_active && !use_wait && last && timing_tick
    |=> state != ext_bus_pkg::st_active)
    else $error("wait inserted though the wait input is ignored");

  align_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == ext_bus_pkg::st_align |-> zone_select_n && read_strobe_n &&
    write_strobe0_n && write_strobe1_n)
    else $error("strobe active during an alignment cycle");

  addr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(start) |-> $stable(ext_address))
    else $error("address moved outside an access start");

  select_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(zone_select_n) |-> read_not_write && access_done &&
    read_strobe_n)
    else $error("access end without rnw high and done");

endmodule

// ---- testbench/ext_wait_device.sv ----
// model of the external memory answering on the wait input
// assumes the select of the bus block; stall set by the bench
`timescale 1ns/10ps

module ext_wait_device (
  input wire logic zone_select_n,
  input wire logic [1:0] stall,
  output logic ext_wait_ready
);
  // pull-up on the pin: ready while no stall is asked for
  // not ready for stall periods of 800 ns from the start of an access;
  // release lands off the clk edges so the synchroniser sees no race
  initial begin
    ext_wait_ready = 1'b1;
    forever begin
      @(negedge zone_select_n);
      if (stall != 2'h0) begin
        ext_wait_ready = 1'b0;
        #(800 * stall + 25);
        ext_wait_ready = 1'b1;
      end
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench of the external bus access sequencer
// assumes a 10 MHz clk and the wait device model on the ready pin
`timescale 1ns/10ps
`include "ext_bus_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
$display("mismatch %s exp %0h got %0h", nm, e, g); end end

module testbench;
  logic clk, reset_n, timing_half, bus_half, timing_double, wide_bus;
  logic honor_wait_input, wait_sample_async, req_valid, req_write;
  logic [1:0] rl, rt, wl, wt, stall;
  logic [2:0] ra, wa;
  logic [`ADDR_W-1:0] req_address, ext_address;
  logic ext_wait_ready, req_ready, access_done, bus_clock_out;
  logic zone_select_n, read_strobe_n, write_strobe0_n, write_strobe1_n;
  logic read_not_write;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  external_bus_access i_external_bus_access (.clk(clk), .reset_n(reset_n),
    .timing_half(timing_half), .bus_half(bus_half),
    .timing_double(timing_double), .honor_wait_input(honor_wait_input),
    .wait_sample_async(wait_sample_async), .wide_bus(wide_bus),
    .read_lead_count(rl), .read_active_count(ra),
    .read_trail_count(rt), .write_lead_count(wl),
    .write_active_count(wa), .write_trail_count(wt),
    .req_valid(req_valid), .req_write(req_write),
    .req_address(req_address), .ext_wait_ready(ext_wait_ready),
    .req_ready(req_ready), .access_done(access_done),
    .bus_clock_out(bus_clock_out), .zone_select_n(zone_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe0_n(write_strobe0_n),
    .write_strobe1_n(write_strobe1_n), .read_not_write(read_not_write),
    .ext_address(ext_address));

  ext_wait_device i_ext_wait_device (.zone_select_n(zone_select_n),
    .stall(stall), .ext_wait_ready(ext_wait_ready));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      end_of_test;
    end
  end

  // one access; phase lengths measured in clk cycles at falling edges
  task automatic acc(input logic wr, input logic [1:0] l, input logic [2:0] a,
    input logic [1:0] t, input logic dbl, input logic [19:0] ad,
    input logic w);
    int tc, m, cnt, lc, ac, n;
    logic ps, pst, st, sel;
    tc = timing_half ? 2 : 1;
    m = dbl ? 2 : 1;
    @(negedge clk);
    // the idle direction gets other counts so a wrong pick shows
    {rl, ra, rt} = wr ? ~{l, a, t} : {l, a, t};
    {wl, wa, wt} = wr ? {l, a, t} : ~{l, a, t};
    timing_double = dbl;
    req_write = wr;
    req_address = ad;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    ps = 1'b1;
    pst = 1'b1;
    cnt = 0;
    lc = 0;
    ac = 0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      sel = zone_select_n;
      st = wr ? write_strobe0_n : read_strobe_n;
      cnt++;
      if (wr) `CHK("strobe1", wide_bus ? st : 1'b1, write_strobe1_n)
      if (!sel && ps) begin
        cnt = 0;
        `CHK("start_bus", 1'b1, bus_clock_out)
        `CHK("address", ad, ext_address)
        `CHK("rnw", ~wr, read_not_write)
      end
      if (!st && pst) begin
        lc = cnt / tc;
        `CHK("lead", l * m * tc, cnt)
        `CHK("fall_edge", (lc % 2 == 0) | ~bus_half, bus_clock_out)
      end
      if (st && !pst) begin
        ac = cnt / tc - lc;
        if (w) `CHK("waited", 1'b1, ac > a * m + 1)
        else `CHK("active", a * m + 1, ac)
        `CHK("rise_edge", (cnt / tc % 2 == 0) | ~bus_half, bus_clock_out)
      end
      if (sel && !ps) begin
        `CHK("tick", 0, cnt % tc)
        `CHK("trail", t * m * tc, cnt - (lc + ac) * tc)
        `CHK("end_edge", (cnt / tc % 2 == 0) | ~bus_half, bus_clock_out)
        `CHK("rnw_end", 1'b1, read_not_write)
        `CHK("done", 1'b1, access_done)
        break;
      end
      ps = sel;
      pst = st;
    end
    `CHK("complete", 1'b1, n < 400)
    @(negedge clk);
    `CHK("done_pulse", 1'b0, access_done)
    `CHK("ready", 1'b1, req_ready)
    `CHK("addr_hold", ad, ext_address)
  endtask

  initial begin
    reset_n = 1'b0;
    {timing_half, bus_half, timing_double, honor_wait_input} = 4'h0;
    {wait_sample_async, req_valid, req_write, wide_bus} = 4'h1;
    {rl, ra, rt, wl, wa, wt, stall} = 16'h0000;
    req_address = 20'h0_0000;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    for (int md = 0; md < 4; md++) begin
      {timing_half, bus_half} = md[1:0];
      acc(1'b0, 2'h1, 3'h1, 2'h1, 1'b0, 20'h1_2345, 1'b0);
      acc(1'b1, 2'h2, 3'h1, 2'h0, 1'b1, 20'hA_BCDE, 1'b0);
      acc(1'b1, 2'h1, 3'h0, 2'h3, 1'b0, 20'h0_00F0, 1'b0);
    end
    {timing_half, bus_half, honor_wait_input, wait_sample_async} = 4'h7;
    stall = 2'h1;
    acc(1'b0, 2'h1, 3'h2, 2'h0, 1'b0, 20'h5_5555, 1'b1);
    acc(1'b1, 2'h1, 3'h1, 2'h0, 1'b1, 20'hA_AAAA, 1'b1);
    acc(1'b0, 2'h2, 3'h2, 2'h0, 1'b0, 20'h3_C3C3, 1'b1);
    {wait_sample_async, wide_bus} = 2'h0;
    acc(1'b1, 2'h1, 3'h2, 2'h2, 1'b0, 20'hF_FFFF, 1'b1);
    honor_wait_input = 1'b0;
    acc(1'b0, 2'h1, 3'h2, 2'h0, 1'b0, 20'h0_1234, 1'b0);
    {honor_wait_input, wait_sample_async, stall} = 4'hC;
    repeat (8) @(negedge clk);
    acc(1'b0, 2'h0, 3'h0, 2'h0, 1'b0, 20'h0_0001, 1'b0);
    end_of_test;
  end
endmodule
